// ### verilog/reset_sequencer_with_wake_counter.sv
`timescale 1ns/10ps
module reset_sequencer_with_wake_counter #(
    parameter logic [12:0] PIN_FLAG_LONG = rst_seq_pkg::PIN_FLAG_POR_CYC
) (
    input wire logic clk_in,
    input wire logic srst_in,
    // Reset sources
    input wire logic power_on_pulse_in,
    input wire logic brownout_req_in,
    input wire logic watchdog_req_in,
    input wire logic bad_opcode_in,
    input wire logic opcode_fetch_in,
    input wire logic unmapped_access_in,
    input wire logic stop_exec_in,
    input wire logic monitor_entry_reset_in,
    input wire logic wake_event_in,
    // Test voltage detection and modes
    input wire logic rst_pin_vtst_in,
    input wire logic irq_pin_vtst_in,
    input wire logic monitor_mode_in,
    input wire logic break_state_in,
    // Reset pin, active low, open drain
    input wire logic reset_pin_n_in,
    output logic reset_pin_n_out,
    output logic reset_pin_oe_out,
    // To the rest of the chip
    output logic internal_reset_out,
    output logic internal_bus_clocks_out,
    output logic clkgen_out_en_out,
    output logic watchdog_disable_out,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out
);
    // ========================================
    // Declarations
    rst_seq_pkg::seq_state_t state_ff;
    rst_seq_pkg::seq_state_t nxt_state;
    logic [rst_seq_pkg::CAUSE_W-1:0] cause_ff;
    logic [1:0] config_ff;
    logic long_seq_ff;
    logic pin_drive_ff;
    logic int_reset_ff;
    logic bus_clk_ff;
    logic clkgen_en_ff;
    logic [12:0] pin_low_cnt_ff;
    logic pin_flag_long_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [1:0] sync_q;
    logic pin_low_s;
    logic wdog_s;
    logic wdog_hit;
    logic fetch_hit;
    logic opc_hit;
    logic any_internal;
    logic long_req;
    logic cnt_clear;
    logic [12:0] base;
    logic [12:0] cnt;
    logic [12:0] wake_len;
    logic [12:0] pin_thr;
    logic wb_req;
    logic seq_last;
    logic wake_last;
    logic drive_on;
    logic por_done;
    logic stop_ok;
    logic pin_flag_hit;
    logic cfg_wr;
    logic [31:0] rd_word;
    cnt_if cnt_bus ();

    // ========================================
    // Recovery counter and synchronisers
    recovery_counter u_counter (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .port(cnt_bus.cnt)
    );

    // Pin rests high (pull-up), watchdog request rests low
    level_sync #(.W(2)) u_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .d_in({watchdog_req_in, ~reset_pin_n_in}),
        .rst_val_in(2'h0),
        .q_out(sync_q)
    );
    assign pin_low_s = sync_q[0]; // RL24
    assign wdog_s = sync_q[1]; // RL6
    assign cnt = cnt_bus.value;

    // ========================================
    // Source decode
    // Pure gates on the test-voltage detectors so noise cannot latch it
    assign watchdog_disable_out = (monitor_mode_in
        && (rst_pin_vtst_in || irq_pin_vtst_in))
        || (break_state_in && rst_pin_vtst_in); // RL12
    assign wdog_hit = wdog_s && !watchdog_disable_out; // RL11
    assign fetch_hit = opcode_fetch_in && unmapped_access_in; // RL15
    assign opc_hit = bad_opcode_in
        || (stop_exec_in && !config_ff[rst_seq_pkg::CFG_STOP_ALLOW]); // RL14
    assign long_req = power_on_pulse_in || brownout_req_in; // RL5
    assign any_internal = long_req || wdog_hit || fetch_hit || opc_hit
        || monitor_entry_reset_in; // RL4 RL17

    // ========================================
    // Sequence timing
    assign base = long_seq_ff ? rst_seq_pkg::POR_WAIT_CYC : 13'h0000;
    assign wake_len = config_ff[rst_seq_pkg::CFG_SHORT_WAKE]
        ? rst_seq_pkg::STOP_SHORT_CYC : rst_seq_pkg::STOP_LONG_CYC; // RL19
    // Counter cleared on entry to a sequence and held through stop
    assign cnt_clear = any_internal || state_ff == rst_seq_pkg::SEQ_STOP
        || nxt_state == rst_seq_pkg::SEQ_STOP; // RL23 RL19
    assign cnt_bus.clear = cnt_clear;

    // ========================================
    // Terminal counts; the counter lags the flops by one edge
    // Compares wrap in 13 bits, as the counter itself does
    assign seq_last = cnt + 13'h0001 == base + rst_seq_pkg::PIN_DRIVE_CYC
        + rst_seq_pkg::RST_TAIL_CYC; // RL3
    assign wake_last = cnt + 13'h0001 == wake_len; // RL19
    assign drive_on = cnt + 13'h0001 < base + rst_seq_pkg::PIN_DRIVE_CYC;
    assign por_done = !long_seq_ff
        || cnt + 13'h0001 >= rst_seq_pkg::POR_WAIT_CYC; // RL9

    // Stop is refused while the pin holds the core
    assign stop_ok = !any_internal && stop_exec_in
        && config_ff[rst_seq_pkg::CFG_STOP_ALLOW] && !pin_low_s;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rst_seq_pkg::SEQ_RUN: begin
                if (stop_ok) begin
                    nxt_state = rst_seq_pkg::SEQ_STOP; // RL19
                end
            end
            rst_seq_pkg::SEQ_ACTIVE: begin
                if (seq_last) begin
                    nxt_state = rst_seq_pkg::SEQ_RUN; // RL3
                end
            end
            rst_seq_pkg::SEQ_STOP: begin
                if (wake_event_in || pin_low_s) begin
                    nxt_state = rst_seq_pkg::SEQ_WAKE;
                end
            end
            rst_seq_pkg::SEQ_WAKE: begin
                if (wake_last) begin
                    nxt_state = rst_seq_pkg::SEQ_RUN; // RL19
                end
            end
        endcase
        // A new internal source always restarts the sequence
        if (any_internal) begin
            nxt_state = rst_seq_pkg::SEQ_ACTIVE; // RL4
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_ff <= rst_seq_pkg::SEQ_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            long_seq_ff <= 1'b0;
        end else if (any_internal) begin
            long_seq_ff <= long_req; // RL5 RL16
        end
    end

    // ========================================
    // Pin drive, internal reset and clock gating
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_drive_ff <= 1'b0;
            int_reset_ff <= 1'b0;
            bus_clk_ff <= 1'b1;
            clkgen_en_ff <= 1'b1;
        end else if (any_internal) begin
            pin_drive_ff <= 1'b1; // RL2
            int_reset_ff <= 1'b1;
            bus_clk_ff <= !long_req; // RL9
            clkgen_en_ff <= 1'b1; // RL9
        end else begin
            unique case (state_ff)
                rst_seq_pkg::SEQ_ACTIVE: begin
                    pin_drive_ff <= drive_on; // RL2 RL8
                    int_reset_ff <= !seq_last; // RL3
                    bus_clk_ff <= por_done; // RL9
                end
                rst_seq_pkg::SEQ_STOP: begin
                    bus_clk_ff <= 1'b0;
                end
                rst_seq_pkg::SEQ_WAKE: begin
                    bus_clk_ff <= nxt_state == rst_seq_pkg::SEQ_RUN; // RL19
                end
                rst_seq_pkg::SEQ_RUN: begin
                    pin_drive_ff <= 1'b0;
                    int_reset_ff <= 1'b0;
                    bus_clk_ff <= nxt_state != rst_seq_pkg::SEQ_STOP;
                end
            endcase
        end
    end

    assign reset_pin_n_out = 1'b0;
    assign reset_pin_oe_out = pin_drive_ff; // RL2 RL17
    // Raw pin halts at once; it needs no clock to stop the core
    assign internal_reset_out = int_reset_ff || !reset_pin_n_in; // RL1 RL22
    assign internal_bus_clocks_out = bus_clk_ff && reset_pin_n_in; // RL22
    assign clkgen_out_en_out = clkgen_en_ff;

    // ========================================
    // Pin-low duration for the pin cause flag
    assign pin_thr = pin_flag_long_ff ? PIN_FLAG_LONG
        : rst_seq_pkg::PIN_FLAG_CYC; // RL7
    // Flag blocked once a power-on or brown-out cause is on record
    assign pin_flag_hit = pin_low_cnt_ff == pin_thr
        && !cause_ff[rst_seq_pkg::CAUSE_POR]
        && !cause_ff[rst_seq_pkg::CAUSE_BROWN]; // RL1

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_low_cnt_ff <= 13'h0000;
        end else if (!pin_low_s || pin_drive_ff) begin
            // Own drive is not an external reset
            pin_low_cnt_ff <= 13'h0000;
        end else if (pin_low_cnt_ff != 13'h1fff) begin
            pin_low_cnt_ff <= pin_low_cnt_ff + 13'h0001; // RL1
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_flag_long_ff <= 1'b0;
        end else if (long_req) begin
            pin_flag_long_ff <= 1'b1; // RL7
        end else if (state_ff == rst_seq_pkg::SEQ_RUN && !pin_low_s) begin
            pin_flag_long_ff <= 1'b0;
        end
    end

    // ========================================
    // Reset cause flags; hardware sets them and power-on clears the others, read by software
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cause_ff <= rst_seq_pkg::CAUSE_RST;
        end else if (power_on_pulse_in) begin
            cause_ff <= 7'h01 << rst_seq_pkg::CAUSE_POR; // RL10
        end else begin
            if (brownout_req_in) begin
                cause_ff[rst_seq_pkg::CAUSE_BROWN] <= 1'b1; // RL16
            end
            if (wdog_hit) begin
                cause_ff[rst_seq_pkg::CAUSE_WDOG] <= 1'b1; // RL11
            end
            if (opc_hit) begin
                cause_ff[rst_seq_pkg::CAUSE_OPC] <= 1'b1; // RL13 RL14
            end
            if (fetch_hit) begin
                cause_ff[rst_seq_pkg::CAUSE_FETCH] <= 1'b1; // RL15
            end
            if (monitor_entry_reset_in) begin
                cause_ff[rst_seq_pkg::CAUSE_MON] <= 1'b1; // RL17
            end
            if (pin_flag_hit) begin
                cause_ff[rst_seq_pkg::CAUSE_PIN] <= 1'b1; // RL1 RL7
            end
        end
    end

    // ========================================
    // Wishbone slave, ack one cycle after strobe
    assign wb_req = wb_cyc_in && wb_stb_in && !ack_ff;
    // Only byte lane 0 carries config bits
    assign cfg_wr = wb_req && wb_we_in && wb_sel_in[0]
        && wb_adr_in == rst_seq_pkg::CONFIG_OFS;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_req;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            config_ff <= rst_seq_pkg::CONFIG_RST;
        end else if (cfg_wr) begin
            config_ff <= wb_dat_in[1:0]; // RL21
        end
    end

    // Read word assembled here, captured only on a read strobe
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_in)
            rst_seq_pkg::CAUSE_OFS: begin
                rd_word[rst_seq_pkg::CAUSE_W-1:0] = cause_ff;
            end
            rst_seq_pkg::CONFIG_OFS: begin
                rd_word[1:0] = config_ff;
            end
            rst_seq_pkg::STATUS_OFS: begin
                rd_word[rst_seq_pkg::STAT_CNT_LSB +: 13] = cnt;
                rd_word[rst_seq_pkg::STAT_INT_RST] = int_reset_ff;
                rd_word[rst_seq_pkg::STAT_CLK_ON] = bus_clk_ff;
                rd_word[rst_seq_pkg::STAT_STOPPED] =
                    state_ff == rst_seq_pkg::SEQ_STOP;
            end
            // Unmapped offsets read as zero
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (wb_req && !wb_we_in) begin
            rdata_ff <= rd_word;
        end
    end

    assign wb_ack_out = ack_ff;
    assign wb_dat_out = rdata_ff;
endmodule : reset_sequencer_with_wake_counter

// ### verilog/rst_seq_pkg.sv
// Operation
// [RL1] Low pin halts all; flag after 67 low cycles unless power-on/brownout.
// [RL2] Internal resets other than power-on and brown-out drive the reset pin low for 32 cycles.
// [RL3] Internal reset stays asserted 32 more cycles after pin drive ends.
// [RL4] Bad fetch, bad opcode, watchdog, brown-out and power-on start the sequence.
// [RL5] Power-on and brown-out first count 4096 cycles with the pin low.
// [RL6] Watchdog request is taken asynchronously and synchronised here.
// [RL7] Pin flag timing is 4163 cycles after power-on/brownout, 67 otherwise.
// [RL8] Power-on holds pin low for 4096+32, releases processor 32 later.
// [RL9] Power-on enables clock generator, holds bus clocks off 4096 cycles.
// [RL10] Power-on sets its cause flag and clears all other flags.
// [RL11] Watchdog overflow resets and sets the watchdog cause flag.
// [RL12] Watchdog disabled only by test voltage in monitor mode or break.
// [RL13] Illegal opcode sets its cause flag and issues a reset.
// [RL14] Stop with stop-allow cleared is treated as an illegal opcode.
// [RL15] Only opcode fetch from unmapped address resets; data access does not.
// [RL16] Brown-out sets its flag, pin low 4096+32, processor free 32 later.
// [RL17] Monitor-entry request causes internal reset with the pin driven low.
// [RL18] Recovery counter is 13 bits wide.
// [RL19] Stop clears counter; wake delay is 32 if short-wake set, else 4096.
// [RL20] Pin reset leaves counter unchanged; counter runs freely otherwise.
// [RL21] Crystal systems should keep short-wake cleared for full recovery.
// [RL22] Pin has a pull-up; any low level stops processing while held.
// [RL23] Internal reset clears the counter, external pin reset does not.
// [RL24] Pin level is synchronised before timing the pin flag.
package rst_seq_pkg;
    // ========================================
    // Widths
    localparam int CNT_W = 13; // RL18
    localparam int CAUSE_W = 7;
    // ========================================
    // Cycle counts of the reference clock
    localparam logic [12:0] POR_WAIT_CYC = 13'h1000;
    localparam logic [12:0] PIN_DRIVE_CYC = 13'h0020;
    localparam logic [12:0] RST_TAIL_CYC = 13'h0020;
    localparam logic [12:0] PIN_FLAG_CYC = 13'h0043;
    localparam logic [12:0] PIN_FLAG_POR_CYC = 13'h1043;
    localparam logic [12:0] STOP_LONG_CYC = 13'h1000;
    localparam logic [12:0] STOP_SHORT_CYC = 13'h0020;
    // ========================================
    // Register byte offsets
    localparam logic [3:0] CAUSE_OFS = 4'h0;
    localparam logic [3:0] CONFIG_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    // ========================================
    // Field positions
    localparam int CAUSE_PIN = 0;
    localparam int CAUSE_POR = 1;
    localparam int CAUSE_WDOG = 2;
    localparam int CAUSE_OPC = 3;
    localparam int CAUSE_FETCH = 4;
    localparam int CAUSE_MON = 5;
    localparam int CAUSE_BROWN = 6;
    localparam int CFG_STOP_ALLOW = 0;
    localparam int CFG_SHORT_WAKE = 1;
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_INT_RST = 16;
    localparam int STAT_CLK_ON = 17;
    localparam int STAT_STOPPED = 18;
    // ========================================
    // Reset values
    localparam logic [CAUSE_W-1:0] CAUSE_RST = 7'h00;
    localparam logic [1:0] CONFIG_RST = 2'h0;
    // ========================================
    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_RUN, SEQ_ACTIVE, SEQ_STOP, SEQ_WAKE
    } seq_state_t;
endpackage : rst_seq_pkg

// ### verilog/cnt_if.sv
`timescale 1ns/10ps
interface cnt_if;
    logic clear;
    logic [rst_seq_pkg::CNT_W-1:0] value;
    modport ctrl (output clear, input value);
    modport cnt (input clear, output value);
endinterface : cnt_if

// ### verilog/level_sync.sv
`timescale 1ns/10ps
module level_sync #(
    parameter int W = 2
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [W-1:0] d_in,
    input wire logic [W-1:0] rst_val_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    // ========================================
    // Two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_ff <= rst_val_in;
            q_ff <= rst_val_in;
        end else begin
            meta_ff <= d_in;
            q_ff <= meta_ff;
        end
    end
    assign q_out = q_ff;
endmodule : level_sync

// ### verilog/recovery_counter.sv
`timescale 1ns/10ps
module recovery_counter (
    input wire logic clk_in,
    input wire logic srst_in,
    cnt_if.cnt port
);
    logic [rst_seq_pkg::CNT_W-1:0] count_ff;
    // ========================================
    // Free-running, wraps; only a clear stops it
    always_ff @(posedge clk_in) begin
        if (srst_in || port.clear) begin
            count_ff <= '0; // RL23
        end else begin
            count_ff <= count_ff + 1'b1; // RL20
        end
    end
    assign port.value = count_ff;
endmodule : recovery_counter

// ### sim/rst_seq_sva.sv
`timescale 1ns/10ps
module rst_seq_sva (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic power_on_pulse_in,
    input wire logic watchdog_req_in,
    input wire logic bad_opcode_in,
    input wire logic rst_pin_vtst_in,
    input wire logic irq_pin_vtst_in,
    input wire logic monitor_mode_in,
    input wire logic break_state_in,
    input wire logic reset_pin_n_in,
    input wire logic reset_pin_n_out,
    input wire logic reset_pin_oe_out,
    input wire logic clkgen_out_en_out,
    input wire logic internal_reset_out,
    input wire logic internal_bus_clocks_out,
    input wire logic watchdog_disable_out,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out
);
    // ==========
    // Drive length, cleared whenever the pin is let go
    logic [12:0] oe_len_ff;
    always_ff @(posedge clk_in) begin
        if (srst_in || !reset_pin_oe_out) begin
            oe_len_ff <= 13'h0000;
        end else begin
            oe_len_ff <= oe_len_ff + 13'h0001;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence wb_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence ack_once;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    // Past guard: a drive cut by reset is no real end
    sequence oe_end;
        $fell(reset_pin_oe_out) && !$past(srst_in);
    endsequence
    sequence wdog_live;
        watchdog_req_in && !watchdog_disable_out
            ##1 (!watchdog_disable_out)[*2];
    endsequence
    // ==========
    // Checks
    a_ack_single:
        assert property (wb_req |=> ack_once) else $error("late ack");
    a_opcode_drive:
        assert property (bad_opcode_in |=> reset_pin_oe_out)
        else $error("no drive on bad opcode");
    a_wdog_taken:
        assert property (wdog_live |=> reset_pin_oe_out)
        else $error("watchdog missed");
    a_wdog_gate:
        assert property (watchdog_disable_out == (break_state_in &&
            rst_pin_vtst_in || monitor_mode_in && (rst_pin_vtst_in ||
            irq_pin_vtst_in))) else $error("bad watchdog gate");
    a_drive_len:
        assert property (oe_end |-> oe_len_ff inside {13'h0020, 13'h1020})
        else $error("wrong drive length");
    a_internal_reset_tail:
        assert property (oe_end |-> internal_reset_out[*8] ##[24:26]
            !internal_reset_out) else $error("wrong reset tail");
    a_pin_halts:
        assert property (!reset_pin_n_in |-> internal_reset_out &&
            !internal_bus_clocks_out) else $error("pin low not halting");
    a_por_hold:
        assert property (power_on_pulse_in |=> (!internal_bus_clocks_out
            && reset_pin_oe_out)[*8]) else $error("clocks on at power-on");
    a_drive_level:
        assert property (reset_pin_oe_out |-> !reset_pin_n_out)
        else $error("pin driven high");
    a_clkgen_on:
        assert property (power_on_pulse_in |=> clkgen_out_en_out)
        else $error("clock generator off at power-on");
endmodule : rst_seq_sva

bind reset_sequencer_with_wake_counter rst_seq_sva chk_u (.*);

// ### sim/rst_pin_model.sv
`timescale 1ns/10ps
module rst_pin_model (
    input wire logic dev_oe_in,
    input wire logic dev_n_in,
    input wire logic ext_low_in,
    output logic pin_n_out
);
    // Pull-up holds the line high unless a party pulls it down
    assign pin_n_out = !(dev_oe_in && !dev_n_in || ext_low_in);
endmodule : rst_pin_model

// ### sim/reset_sequencer_with_wake_counter_tb_top.sv
`timescale 1ns/10ps
module reset_sequencer_with_wake_counter_tb_top;
    // ==========
    // Signals
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] src = 8'h00;
    logic [3:0] mode = 4'h0;
    wire logic power_on_pulse_in, brownout_req_in, watchdog_req_in;
    wire logic bad_opcode_in, opcode_fetch_in, stop_exec_in;
    wire logic monitor_entry_reset_in, unmapped_access_in;
    wire logic monitor_mode_in, break_state_in;
    wire logic rst_pin_vtst_in, irq_pin_vtst_in;
    logic wake_event_in = 1'b0;
    logic ext_low = 1'b0;
    logic reset_pin_n_in, reset_pin_n_out, reset_pin_oe_out;
    logic internal_reset_out, internal_bus_clocks_out;
    logic clkgen_out_en_out, watchdog_disable_out, wb_ack_out;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd_val;
    logic [63:0] exp_q[$];
    logic [7:0] srcs [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h90,
        8'h20, 8'h40};
    logic [6:0] causes [7] = '{7'h02, 7'h40, 7'h04, 7'h08, 7'h10,
        7'h08, 7'h20};
    int mismatches = 0, total_checks = 0, n, t, len;
    assign {unmapped_access_in, monitor_entry_reset_in, stop_exec_in,
        opcode_fetch_in, bad_opcode_in, watchdog_req_in,
        brownout_req_in, power_on_pulse_in} = src;
    assign {monitor_mode_in, break_state_in, rst_pin_vtst_in,
        irq_pin_vtst_in} = mode;
    reset_sequencer_with_wake_counter #(.PIN_FLAG_LONG(13'h0064))
        dut_u (.*);
    rst_pin_model pin_u (.dev_oe_in(reset_pin_oe_out),
        .dev_n_in(reset_pin_n_out), .ext_low_in(ext_low),
        .pin_n_out(reset_pin_n_in));
    initial forever #50 clk_in = ~clk_in;
    // ==========
    // Tasks
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    task automatic check(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic check_cnt(input int got, lo, hi);
        total_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask : check_cnt
    task automatic count(ref logic s, input logic v, input int lim,
        input bit fatal, output int c);
        c = 0;
        while (s === v && c < lim) begin
            @(posedge clk_in);
            c++;
        end
        if (c == lim && fatal) begin
            mismatches++;
            results();
        end
    endtask : count
    task automatic wb(input logic we, input logic [3:0] a,
        input logic [31:0] d, m);
        @(posedge clk_in);
        exp_q.push_back({m, d & m});
        {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, we};
        wb_adr_in <= a;
        wb_dat_in <= d;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 20);
        if (n == 20) begin
            mismatches++;
            results();
        end
        rd_val = wb_dat_out;
        {wb_cyc_in, wb_stb_in} <= 2'b00;
    endtask : wb
    task automatic rst();
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
    endtask : rst
    // Random gap so sources land at varied counter phases
    task automatic fire(input logic [7:0] s);
        repeat ($urandom_range(7, 0)) @(posedge clk_in);
        @(posedge clk_in);
        src <= s;
        @(posedge clk_in);
        src <= 8'h00;
    endtask : fire
    initial begin : watch_bus
        logic [63:0] e;
        forever begin
            @(posedge clk_in);
            if (wb_ack_out === 1'b1 && exp_q.size() > 0) begin
                e = exp_q.pop_front();
                check(wb_dat_out & e[63:32], e[31:0]);
            end
        end
    end
    initial begin
        #(100000 * 100);
        mismatches++;
        results();
    end
    // ==========
    // Scenarios
    initial begin : main
        int cfg;
        n = $urandom(32'h6548);
        repeat (8) @(posedge clk_in);
        srst_in <= 1'b0;
        wb(0, 4'h0, 32'h0, 32'h7f);
        wb(0, 4'h4, 32'h0, 32'h3);
        wb(0, 4'h8, 32'h20000, 32'h70000);
        cfg = $urandom_range(3, 0);
        wb(1, 4'h4, 32'(cfg), 32'h0);
        wb(0, 4'h4, 32'(cfg), 32'h3);
        wb(1, 4'h0, 32'h7f, 32'h0);
        wb(0, 4'h0, 32'h0, 32'h7f);
        wb(0, 4'hc, 32'h0, 32'hffffffff);
        for (int i = 0; i < 7; i++) begin
            rst();
            fire(srcs[i]);
            t = i < 2 ? 4128 : 32;
            count(reset_pin_oe_out, 1'b0, 40, 1'b1, n);
            count(reset_pin_oe_out, 1'b1, 5000, 1'b1, len);
            check_cnt(len, t, t);
            count(internal_reset_out, 1'b1, 100, 1'b1, len);
            check_cnt(len, 32, 32);
            wb(0, 4'h0, {25'h0, causes[i]}, 32'h7f);
        end
        rst();
        fire(8'h80);
        count(reset_pin_oe_out, 1'b0, 12, 1'b0, len);
        check_cnt(len, 12, 12);
        mode <= 4'b1010;
        fire(8'h04);
        count(reset_pin_oe_out, 1'b0, 12, 1'b0, len);
        check_cnt(len, 12, 12);
        for (int i = 0; i < 17; i++) begin
            @(posedge clk_in);
            mode <= 4'(i);
        end
        // Pin not held long enough, then held long enough
        for (int i = 40; i < 80; i += 30) begin
            rst();
            repeat (20) @(posedge clk_in);
            ext_low <= 1'b1;
            repeat (i) @(posedge clk_in);
            ext_low <= 1'b0;
            repeat (4) @(posedge clk_in);
            wb(0, 4'h0, 32'(i > 67), 32'h7f);
            wb(0, 4'h8, 32'h0, 32'h0);
            check_cnt(rd_val[12:0], i + 20, 8191);
        end
        rst();
        for (int i = 0; i < 2; i++) begin
            wb(1, 4'h4, 32'(3 - 2 * i), 32'h0);
            fire(8'h20);
            repeat (3) @(posedge clk_in);
            wb(0, 4'h8, 32'h40000, 32'h71fff);
            @(posedge clk_in);
            wake_event_in <= 1'b1;
            @(posedge clk_in);
            wake_event_in <= 1'b0;
            count(internal_bus_clocks_out, 1'b0, 5000, 1'b1, len);
            check_cnt(len, i ? 4094 : 30, i ? 4098 : 34);
        end
        results();
    end
endmodule : reset_sequencer_with_wake_counter_tb_top
